// >>> design/jacp_dev.sv
// Purpose: device end of the serial configuration port with one command register
// Assumes: serial clock and all pins are sampled by clk after two flip-flops
// Notes:   responds only where the address matches the low four bits of its own channel offset
`timescale 1ns/1ps
`default_nettype none
// Operation
// - host select high enables serial port
// - five-bit register: rate, disable, bandwidth, edge, fifo
// - channel pins pick responding register offset
// - master runs clock, select low before rise
// - eight header bits sampled on rising edges
// - first header bit: 1 read, 0 write
// - four address bits follow, LSB first
// - A4, A5 zero; A6 ignored
// - read: output starts at falling edge eight
// - read data D0..D4 LSB first, falling edges
// - write data D0..D7 LSB first, rising edges
// - output released unless returning read data
// - host select low: pins configure directly
module jacp_dev (
  input  wire logic            clk,
  input  wire logic            rst,
  jacp_if.dev                  link,
  input  wire logic            host_or_pin_config_select,
  input  wire logic            channel_addr_hi,
  input  wire logic            channel_addr_lo,
  output var  logic            line_rate_select,
  output var  logic            attenuator_disable,
  output var  logic            loop_bandwidth_select,
  output var  logic            clock_edge_select,
  output var  logic            fifo_size_select,
  output var jacp_pkg::jacp_cfg_t config_word
);
  import jacp_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE   = 3'h0,
    D_HEADER = 3'h1,
    D_READ   = 3'h3,
    D_WRITE  = 3'h2,
    D_DONE   = 3'h6
  } jacp_dstate_t;

  logic [6:0]   pins_s;
  logic         cs_n_s;
  logic         sclk_s;
  logic         sdi_s;
  logic         line_s;
  logic         host_s;
  logic         ch_hi_s;
  logic         ch_lo_s;
  logic         sclk_d;
  logic         rise;
  logic         fall;
  logic         active;
  logic         hit;
  logic [4:0]   cnt;
  logic [2:0]   idx;
  logic [7:0]   hdr;
  logic [7:0]   wsh;
  logic [7:0]   own_offset;
  jacp_cfg_t    cfg;
  jacp_dstate_t state;
  jacp_dstate_t next_state;

  jacp_sync #(
    .W (7)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({link.chip_select_n, link.sclk, link.sdi, link.serial_out_line,
           host_or_pin_config_select, channel_addr_hi, channel_addr_lo}),
    .q   (pins_s)
  );

  assign {cs_n_s, sclk_s, sdi_s, line_s, host_s, ch_hi_s, ch_lo_s} = pins_s;

  // edges of the serial clock as seen in the clk domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // the port only listens in host mode and while selected
  assign active = host_s & ~cs_n_s;
  assign idx    = cnt[2:0];

  // channel 3 has no register, so such a device never answers
  assign own_offset = jacp_chan_offset({ch_hi_s, ch_lo_s});
  // address bits arrive LSB first; A4..A6 take no part in the match
  assign hit = (hdr[HDR_ADDR_HI:HDR_ADDR_LO] == own_offset[3:0]) && (own_offset != NO_REGISTER);

  always_comb begin
    next_state = state;
    case (state)
      D_IDLE: begin
        next_state = D_HEADER;
      end
      D_HEADER: begin
        if (rise && cnt == HDR_LAST_CNT) begin
          if (!hit) begin
            next_state = D_DONE;
          end else if (hdr[HDR_RW]) begin
            next_state = D_READ;
          end else begin
            next_state = D_WRITE;
          end
        end
      end
      D_READ: begin
        if (fall && cnt == RD_END_CNT) begin
          next_state = D_DONE;
        end
      end
      D_WRITE: begin
        if (rise && cnt == WR_LAST_CNT) begin
          next_state = D_DONE;
        end
      end
      D_DONE: begin
        next_state = D_DONE;
      end
      default: begin
        next_state = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= D_IDLE;
    end else if (!active) begin
      state <= D_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // rising-edge counter restarts with every new selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 5'h00;
    end else if (!active) begin
      cnt <= 5'h00;
    end else if (rise && cnt != CNT_MAX) begin
      cnt <= cnt + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hdr <= 8'h00;
    end else if (active && rise && cnt < DATA_CNT) begin
      hdr[idx] <= sdi_s;
    end
  end

  // write data is collected whole and committed only on the eighth bit,
  // so an aborted write leaves the register untouched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wsh <= 8'h00;
    end else if (state == D_WRITE && rise && cnt >= DATA_CNT) begin
      wsh[idx] <= sdi_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= CFG_RESET;
    end else if (state == D_WRITE && rise && cnt == WR_LAST_CNT) begin
      cfg <= wsh[CFG_W-1:0];
    end
  end

  // read data changes on falling edges from edge eight on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.sdo    <= 1'b0;
      link.sdo_oe <= 1'b0;
    end else if (state != D_READ || !active) begin
      link.sdo    <= 1'b0;
      link.sdo_oe <= 1'b0;
    end else if (fall && cnt >= DATA_CNT && cnt < RD_END_CNT) begin
      link.sdo    <= cfg[idx];
      link.sdo_oe <= 1'b1;
    end else if (fall && cnt == RD_END_CNT) begin
      link.sdo_oe <= 1'b0;
    end
  end

  // in pin mode the shared pins set the configuration directly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_rate_select      <= 1'b0;
      attenuator_disable    <= 1'b0;
      loop_bandwidth_select <= 1'b0;
      clock_edge_select     <= 1'b0;
      fifo_size_select      <= 1'b0;
    end else if (host_s) begin
      line_rate_select      <= cfg[FLD_LINE_RATE];
      attenuator_disable    <= cfg[FLD_ATTN_DIS];
      loop_bandwidth_select <= cfg[FLD_LOOP_BW];
      clock_edge_select     <= cfg[FLD_CLK_EDGE];
      fifo_size_select      <= cfg[FLD_FIFO_SIZE];
    end else begin
      line_rate_select      <= cs_n_s;
      attenuator_disable    <= line_s;
      loop_bandwidth_select <= ch_lo_s;
      clock_edge_select     <= sdi_s;
      fifo_size_select      <= sclk_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_word <= CFG_RESET;
    end else begin
      config_word <= cfg;
    end
  end

endmodule : jacp_dev
`default_nettype wire

// >>> design/jacp_pkg.sv
// Purpose: shared constants and types for the serial configuration port (both ends)
// Assumes: 25 MHz system clock on both ends
// Notes:   bit counts are counts of rising serial clock edges since chip select went low
package jacp_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // serial clock made by the master end; half period must cover the 240 ns high/low minimum
  localparam int SCLK_HALF_NS  = 320;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // chip select low to first rising edge; met because select falls with a falling edge
  localparam int CS_SETUP_NS   = 50;
  localparam int CS_SETUP_CYC  = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // chip select inactive time between transfers
  localparam int CS_GAP_NS     = 250;
  localparam int CS_GAP_CYC    = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] DIV_LAST = 4'(SCLK_HALF_CYC - 1);
  localparam logic [3:0] GAP_LAST = 4'(CS_GAP_CYC - 1);

  // frame layout, in rising-edge counts
  localparam logic [4:0] HDR_LAST_CNT = 5'h07;
  localparam logic [4:0] DATA_CNT     = 5'h08;
  localparam logic [4:0] RD_END_CNT   = 5'h0D;
  localparam logic [4:0] WR_END_CNT   = 5'h10;
  localparam logic [4:0] WR_LAST_CNT  = 5'h0F;
  localparam logic [4:0] CNT_MAX      = 5'h1F;

  // header bit positions, first bit on the wire is position 0
  localparam int HDR_RW      = 0;
  localparam int HDR_ADDR_LO = 1;
  localparam int HDR_ADDR_HI = 4;

  // command register fields
  localparam int CFG_W         = 5;
  localparam int FLD_LINE_RATE = 4;
  localparam int FLD_ATTN_DIS  = 3;
  localparam int FLD_LOOP_BW   = 2;
  localparam int FLD_CLK_EDGE  = 1;
  localparam int FLD_FIFO_SIZE = 0;

  typedef logic [CFG_W-1:0] jacp_cfg_t;

  localparam jacp_cfg_t CFG_RESET = 5'h00;

  // command register offsets per channel address
  localparam logic [7:0] CHANNEL0_CONFIG = 8'h05;
  localparam logic [7:0] CHANNEL1_CONFIG = 8'h0D;
  localparam logic [7:0] CHANNEL2_CONFIG = 8'h15;
  localparam logic [7:0] NO_REGISTER     = 8'hFF;

  function automatic logic [7:0] jacp_chan_offset(input logic [1:0] ch);
    case (ch)
      2'h0:    jacp_chan_offset = CHANNEL0_CONFIG;
      2'h1:    jacp_chan_offset = CHANNEL1_CONFIG;
      2'h2:    jacp_chan_offset = CHANNEL2_CONFIG;
      default: jacp_chan_offset = NO_REGISTER;
    endcase
  endfunction : jacp_chan_offset

  // whole frame, index 0 goes out first; bits 5..7 of the header stay zero
  function automatic logic [15:0] jacp_frame(input logic       rd,
                                             input logic [3:0] addr,
                                             input logic [7:0] data);
    jacp_frame = {(rd ? 8'h00 : data), 3'h0, addr, rd};
  endfunction : jacp_frame

endpackage : jacp_pkg

// >>> design/jacp_if.sv
// Purpose: four-wire serial port wiring between master end and device end
// Assumes: serial output line is shared with the direct attenuator-disable pin
// Notes:   line level is resolved here from the device output enable
`timescale 1ns/1ps
`default_nettype none
interface jacp_if;
  logic chip_select_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic hw_dja;
  logic serial_out_line;

  // while the device does not drive, the pin carries the master's direct setting
  assign serial_out_line = sdo_oe ? sdo : hw_dja;

  modport dev (
    input  chip_select_n,
    input  sclk,
    input  sdi,
    input  serial_out_line,
    output sdo,
    output sdo_oe
  );

  modport host (
    output chip_select_n,
    output sclk,
    output sdi,
    output hw_dja,
    input  serial_out_line
  );
endinterface : jacp_if
`default_nettype wire

// >>> design/jacp_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are levels, slow against clk
// Notes:   only the second stage may be read
`timescale 1ns/1ps
`default_nettype none
module jacp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : jacp_sync
`default_nettype wire

// >>> design/jacp_host.sv
// Purpose: master end: makes the serial clock and runs read and write frames
// Assumes: one request at a time, taken only while not busy
// Notes:   read data is sampled through a synchroniser, hence the long half period
`timescale 1ns/1ps
`default_nettype none
module jacp_host (
  input  wire logic       clk,
  input  wire logic       rst,
  jacp_if.host            link,
  input  wire logic       start,
  input  wire logic       read_not_write,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       pin_attn_disable,
  output logic            busy,
  output var  logic       done,
  output var  logic [4:0] rd_data
);
  import jacp_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_WAIT  = 2'h1,
    H_SHIFT = 2'h3,
    H_GAP   = 2'h2
  } jacp_hstate_t;

  jacp_hstate_t state;
  logic [3:0]   div;
  logic         tick;
  logic         rise_ev;
  logic         fall_ev;
  logic         sdo_s;
  logic         rd;
  logic [15:0]  frame;
  logic [4:0]   bitcnt;
  logic [4:0]   last;
  logic [3:0]   gap;

  jacp_sync #(
    .W (1)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (link.serial_out_line),
    .q   (sdo_s)
  );

  // free-running serial clock, present before any selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div       <= 4'h0;
      link.sclk <= 1'b0;
    end else if (tick) begin
      div       <= 4'h0;
      link.sclk <= ~link.sclk;
    end else begin
      div       <= div + 4'h1;
    end
  end

  assign tick    = (div == DIV_LAST);
  assign rise_ev = tick & ~link.sclk;
  assign fall_ev = tick & link.sclk;
  assign busy    = (state != H_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.hw_dja <= 1'b0;
    end else begin
      link.hw_dja <= pin_attn_disable;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state              <= H_IDLE;
      link.chip_select_n <= 1'b1;
      link.sdi           <= 1'b0;
      rd                 <= 1'b0;
      frame              <= 16'h0000;
      bitcnt             <= 5'h00;
      last               <= 5'h00;
      gap                <= 4'h0;
      done               <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        H_IDLE: begin
          if (start) begin
            rd    <= read_not_write;
            frame <= jacp_frame(read_not_write, reg_addr, wr_data);
            last  <= read_not_write ? RD_END_CNT : WR_END_CNT;
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          // select falls with a falling edge: a half period before the first rise
          if (fall_ev) begin
            link.chip_select_n <= 1'b0;
            link.sdi           <= frame[0];
            bitcnt             <= 5'h00;
            state              <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (rise_ev) begin
            bitcnt <= bitcnt + 5'h01;
          end else if (fall_ev) begin
            if (bitcnt == last) begin
              link.chip_select_n <= 1'b1;
              link.sdi           <= 1'b0;
              gap                <= 4'h0;
              state              <= H_GAP;
            end else begin
              link.sdi <= frame[bitcnt[3:0]];
            end
          end
        end
        H_GAP: begin
          if (gap == GAP_LAST) begin
            done  <= 1'b1;
            state <= H_IDLE;
          end else begin
            gap <= gap + 4'h1;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // read bits are taken on the rising edge after the device changed them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 5'h00;
    end else if (state == H_IDLE && start) begin
      rd_data <= 5'h00;
    end else if (state == H_SHIFT && rd && rise_ev && bitcnt >= DATA_CNT && bitcnt < RD_END_CNT) begin
      rd_data[bitcnt[2:0]] <= sdo_s;
    end
  end

endmodule : jacp_host
`default_nettype wire

// >>> verif/jacp_props.sv
// Purpose: wire-level checks on the serial port between master and device ends
// Assumes: one clk domain, serial half period of 8 clk
// Notes:   watches the joining interface only
`timescale 1ns/1ps
`default_nettype none
module jacp_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_cs_setup;
    $fell(chip_select_n) |-> (!sclk)[*2];
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("select fell too near a rise");
  property p_sdi_hold;
    sclk && $past(sclk) |-> $stable(sdi);
  endproperty
  a_sdi_hold: assert property (p_sdi_hold) else $error("sdi moved while clock high");
  property p_oe_start;
    $rose(sdo_oe) |-> !chip_select_n && !sclk;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("drive began off a falling edge");
  property p_sdo_stable;
    sdo_oe && sclk |-> $stable(sdo);
  endproperty
  a_sdo_stable: assert property (p_sdo_stable) else $error("sdo moved while clock high");
  // five bits of 16 clk each, both ends seen through the same sync delay
  property p_oe_len;
    $rose(sdo_oe) |-> ##75 sdo_oe ##[1:10] !sdo_oe;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("read drive not five bits long");
  property p_release;
    $rose(chip_select_n) |-> ##[0:4] !sdo_oe;
  endproperty
  a_release: assert property (p_release) else $error("sdo still driven after deselect");
  // select falls with a falling edge: write frames span 16 periods, reads 13
  property p_frame_len;
    $fell(chip_select_n) && !sdi |-> ##255 !chip_select_n ##1 chip_select_n;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("write frame not sixteen bits");
  property p_read_len;
    $fell(chip_select_n) && sdi |-> ##207 !chip_select_n ##1 chip_select_n;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read frame not thirteen bits");
  property p_gap;
    $rose(chip_select_n) |-> chip_select_n[*7];
  endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
endmodule : jacp_props
`default_nettype wire

// >>> verif/test_jitter_atten_serial_config_port.sv
// Purpose: master end driving device end through the serial port
// Assumes: 25 MHz clk, one device instance, channel pins set by the bench
// Notes:   pin_attn_disable shows on the shared line whenever the device is silent
`timescale 1ns/1ps
`default_nettype none
module test_jitter_atten_serial_config_port;
  import jacp_pkg::*;
  logic       clk, rst, start, read_not_write, pin_attn_disable, busy, done;
  logic       host_sel, ch_hi, ch_lo;
  logic [3:0] reg_addr;
  logic [7:0] wr_data;
  logic [4:0] rd_data, fields;
  jacp_cfg_t  config_word;
  int         fails, n_tests;

  jacp_if bus ();
  jacp_host u_jacp_host (.clk(clk), .rst(rst), .link(bus), .start(start),
    .read_not_write(read_not_write), .reg_addr(reg_addr), .wr_data(wr_data),
    .pin_attn_disable(pin_attn_disable), .busy(busy), .done(done), .rd_data(rd_data));
  jacp_dev u_jacp_dev (.clk(clk), .rst(rst), .link(bus), .host_or_pin_config_select(host_sel),
    .channel_addr_hi(ch_hi), .channel_addr_lo(ch_lo), .line_rate_select(fields[4]),
    .attenuator_disable(fields[3]), .loop_bandwidth_select(fields[2]),
    .clock_edge_select(fields[1]), .fifo_size_select(fields[0]), .config_word(config_word));
  jacp_props u_props (.clk(clk), .rst(rst), .chip_select_n(bus.chip_select_n),
    .sclk(bus.sclk), .sdi(bus.sdi), .sdo(bus.sdo), .sdo_oe(bus.sdo_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // one frame; done is looked at on falling edges so the pulse is never missed
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    start <= 1'b1;
    read_not_write <= rd;
    reg_addr <= a;
    wr_data <= d;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    chk("busy", 8'(busy), 8'h01);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 2000);
    if (n >= 2000) chk("done", 8'h00, 8'h01);
    chk("busy idle", 8'(busy), 8'h00);
  endtask : xfer

  task automatic t_write_read;
    logic [4:0] v [2];
    v = '{5'h16, 5'h09};
    foreach (v[i]) begin
      xfer(1'b0, 4'h5, {3'h5, v[i]});
      repeat (4) @(negedge clk);
      chk("config_word", 8'(config_word), 8'(v[i]));
      chk("fields", 8'(fields), 8'(v[i]));
      xfer(1'b1, 4'h5, 8'h00);
      chk("rd_data", 8'(rd_data), 8'(v[i]));
    end
    $display("t_write_read finished");
  endtask : t_write_read

  task automatic t_other_addr;
    @(posedge clk);
    pin_attn_disable <= 1'b1;
    xfer(1'b0, 4'hD, 8'h1F);
    chk("config_word", 8'(config_word), 8'h09);
    xfer(1'b1, 4'hD, 8'h00);
    chk("rd_data idle line", 8'(rd_data), 8'h1F);
    @(posedge clk);
    pin_attn_disable <= 1'b0;
    $display("t_other_addr finished");
  endtask : t_other_addr

  task automatic t_channels;
    @(posedge clk);
    ch_lo <= 1'b1;
    xfer(1'b0, 4'hD, 8'hEA);
    chk("config_word ch1", 8'(config_word), 8'h0A);
    xfer(1'b0, 4'h5, 8'h1F);
    chk("config_word ch1", 8'(config_word), 8'h0A);
    xfer(1'b1, 4'hD, 8'h00);
    chk("rd_data ch1", 8'(rd_data), 8'h0A);
    @(posedge clk);
    ch_lo <= 1'b0;
    ch_hi <= 1'b1;
    // channel 2 decodes only the low address nibble
    xfer(1'b0, 4'h5, 8'h13);
    chk("config_word ch2", 8'(config_word), 8'h13);
    $display("t_channels finished");
  endtask : t_channels

  task automatic t_pin_mode;
    @(posedge clk);
    host_sel <= 1'b0;
    ch_hi <= 1'b0;
    ch_lo <= 1'b1;
    pin_attn_disable <= 1'b1;
    repeat (6) @(negedge clk);
    chk("attenuator_disable", 8'(fields[3]), 8'h01);
    chk("clock_edge_select", 8'(fields[1]), 8'h00);
    chk("loop_bandwidth_select", 8'(fields[2]), 8'h01);
    chk("line_rate_select", 8'(fields[4]), 8'h01);
    // channel 1 would match this address in host mode, so only pin mode stops it
    xfer(1'b0, 4'hD, 8'h04);
    @(posedge clk);
    host_sel <= 1'b1;
    ch_hi <= 1'b1;
    ch_lo <= 1'b0;
    repeat (6) @(negedge clk);
    chk("config_word", 8'(config_word), 8'h13);
    chk("fields", 8'(fields), 8'h13);
    $display("t_pin_mode finished");
  endtask : t_pin_mode

  initial begin
    #1_000_000;
    fails++;
    results();
  end

  initial begin
    fails = 0;
    n_tests = 0;
    rst = 1'b1;
    start = 1'b0;
    read_not_write = 1'b0;
    reg_addr = 4'h0;
    wr_data = 8'h00;
    pin_attn_disable = 1'b0;
    host_sel = 1'b1;
    ch_hi = 1'b0;
    ch_lo = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    chk("config_word reset", 8'(config_word), 8'h00);
    chk("sdo_oe reset", 8'(bus.sdo_oe), 8'h00);
    t_write_read();
    t_other_addr();
    t_channels();
    t_pin_mode();
    results();
  end
endmodule : test_jitter_atten_serial_config_port
`default_nettype wire
